/* File: src/pan_cfg.svh */
// Constants of the auto-negotiation management register bank.
// Assumes inclusion by bare name from the package and the register bank.
`ifndef PAN_CFG_SVH
`define PAN_CFG_SVH

// Bus widths.
`define PAN_AXI_AW        8
`define PAN_AXI_DW        32
`define PAN_REG_W         16
`define PAN_IDX_W         6
`define PAN_IDX_LSB       2
`define PAN_STRB_W        4

// Register indices; the byte address is four times the index.
`define PAN_IDX_NP        6'h08
`define PAN_IDX_EXT       6'h0F
`define PAN_IDX_ICTL      6'h10
`define PAN_IDX_LB        6'h11
`define PAN_IDX_EVT_STAT  6'h18
`define PAN_IDX_EVT_MASK  6'h19

// Field positions.
`define PAN_ICTL_EN_BIT   0
`define PAN_ICTL_STAT_BIT 1
`define PAN_LB_POS_BIT    0
`define PAN_EVT_AN_BIT    0
`define PAN_EVT_PAGE_BIT  1
`define PAN_EVT_W         2
`define PAN_LANE0         0
`define PAN_LANE1         1
`define PAN_LANE_W        8

// Fixed and reset values.
`define PAN_EXT_STATUS_VAL 16'h8000
`define PAN_ICTL_EN_RST    1'h1
`define PAN_EVT_MASK_RST   2'h0
`define PAN_RESP_OKAY      2'h0
`define PAN_RESP_SLVERR    2'h2

`endif

/* File: src/pan_pkg.sv */
// Types shared by the auto-negotiation management register bank.
// Assumes the constants header is on the include path.
`include "pan_cfg.svh"
`default_nettype none

package pan_pkg;

    // One received next page, packed in register bit order.
    typedef struct packed {
        logic                  more_pages;
        logic                  ack;
        logic                  msg_page;
        logic                  ack2;
        logic                  toggle;
        logic [10:0]           code;
    } pan_page_s;

    // Complete state of the register bank.
    typedef struct packed {
        logic                  aw_held;
        logic [`PAN_IDX_W-1:0] aw_idx;
        logic                  w_held;
        logic [`PAN_REG_W-1:0] wdata;
        logic [1:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [`PAN_REG_W-1:0] rdata;
        pan_page_s             np_page;
        logic                  an_irq_en;
        logic                  an_irq_stat;
        logic                  lb_pos;
        logic                  strap_done;
        logic                  mac_lb;
        logic                  xcvr_lb;
        logic [`PAN_EVT_W-1:0] evt_stat;
        logic [`PAN_EVT_W-1:0] evt_mask;
    } pan_state_s;

endpackage : pan_pkg

`default_nettype wire

/* File: src/pan_regs.sv */
// Auto-negotiation management register bank: received next page, extended
// status, auto-negotiation interrupt control and loopback position.
// Assumes AXI4-Lite on I_MCLK and page and completion events from PCS logic
// on the same clock.
//
// Design decision made here: the AXI4-Lite slave port.
`include "pan_cfg.svh"
`default_nettype none

// What this block does
// - Bit 15 shows partner has more pages.
// - Bit 14 shows received acknowledge indication.
// - Bits 10:0 hold received code field.
// - Bit 12 shows partner can comply.
// - Bit 11 shows received toggle value.
// - Extended status bit 15 reads one.
// - Extended status bits 14:12 read zero.
// - Completion sets status while interrupt enabled.
// - Status holds until software writes zero.
// - Disabled interrupt forces status to zero.
// - Interrupt output follows the status bit.
// - Read/write enable bit, reset value one.
// - Position zero loops inside MAC.
// - Position one loops inside transceiver.
// - Loopback only while control loopback bit set.
module pan_regs (
    // Clock and reset.
    input  wire logic                     I_MCLK,
    input  wire logic                     I_RST,
    // AXI4-Lite write address and data.
    input  wire logic                     I_AWVALID,
    output logic                          O_AWREADY,
    input  wire logic [`PAN_AXI_AW-1:0]   I_AWADDR,
    input  wire logic                     I_WVALID,
    output logic                          O_WREADY,
    input  wire logic [`PAN_AXI_DW-1:0]   I_WDATA,
    input  wire logic [`PAN_STRB_W-1:0]   I_WSTRB,
    // AXI4-Lite write response.
    output logic                          O_BVALID,
    input  wire logic                     I_BREADY,
    output logic [1:0]                    O_BRESP,
    // AXI4-Lite read.
    input  wire logic                     I_ARVALID,
    output logic                          O_ARREADY,
    input  wire logic [`PAN_AXI_AW-1:0]   I_ARADDR,
    output logic                          O_RVALID,
    input  wire logic                     I_RREADY,
    output logic [`PAN_AXI_DW-1:0]        O_RDATA,
    output logic [1:0]                    O_RRESP,
    // Link-side events and received page.
    input  wire logic                     I_AN_DONE,
    input  wire logic                     I_PAGE_VALID,
    input  wire pan_pkg::pan_page_s       I_PAGE,
    // Loopback control.
    input  wire logic                     I_LOOPBACK_EN,
    input  wire logic                     I_LOOPBACK_POS_DEFAULT,
    output logic                          O_MAC_LOOPBACK,
    output logic                          O_XCVR_LOOPBACK,
    // Interrupts.
    output logic                          O_AUTONEG_IRQ_OUT,
    output logic                          O_IRQ
);
    import pan_pkg::*;

    pan_state_s              s_r;
    pan_state_s              s_nxt;
    logic                    aw_hs;
    logic                    w_hs;
    logic                    ar_hs;
    logic                    wr_fire;
    logic                    wr_lane0;
    logic [`PAN_IDX_W-1:0]   ar_idx;
    logic                    wr_ictl;
    logic                    stat_clr_wr;
    logic                    en_off_wr;
    logic [`PAN_REG_W-1:0]   rd_word;
    logic                    rd_hit;
    logic [`PAN_EVT_W-1:0]   evt_set;
    logic [`PAN_EVT_W-1:0]   evt_clr;

    // Handshake outputs are combinational from the held flags and the response valid flags.
    assign O_AWREADY = !s_r.aw_held && !s_r.bvalid;
    assign O_WREADY  = !s_r.w_held && !s_r.bvalid;
    assign O_ARREADY = !s_r.rvalid;
    assign aw_hs     = I_AWVALID && O_AWREADY;
    assign w_hs      = I_WVALID && O_WREADY;
    assign ar_hs     = I_ARVALID && O_ARREADY;
    assign ar_idx    = I_ARADDR[`PAN_AXI_AW-1:`PAN_IDX_LSB];

    // A write is carried out once address and data are both held.
    assign wr_fire     = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign wr_lane0    = wr_fire && s_r.wstrb[`PAN_LANE0];
    assign wr_ictl     = wr_lane0 && (s_r.aw_idx == `PAN_IDX_ICTL);
    assign stat_clr_wr = wr_ictl && !s_r.wdata[`PAN_ICTL_STAT_BIT];
    assign en_off_wr   = wr_ictl && !s_r.wdata[`PAN_ICTL_EN_BIT];

    assign evt_set = {I_PAGE_VALID, I_AN_DONE};
    assign evt_clr = (wr_lane0 && (s_r.aw_idx == `PAN_IDX_EVT_STAT)) ?
                     s_r.wdata[`PAN_EVT_W-1:0] : '0;

    // Read decode; unused bits of every register stay zero.
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (ar_idx)
            `PAN_IDX_NP: begin
                rd_word = s_r.np_page;
            end
            `PAN_IDX_EXT: begin
                rd_word = `PAN_EXT_STATUS_VAL;
            end
            `PAN_IDX_ICTL: begin
                rd_word[`PAN_ICTL_STAT_BIT] = s_r.an_irq_stat;
                rd_word[`PAN_ICTL_EN_BIT]   = s_r.an_irq_en;
            end
            `PAN_IDX_LB: begin
                rd_word[`PAN_LB_POS_BIT] = s_r.lb_pos;
            end
            `PAN_IDX_EVT_STAT: begin
                rd_word[`PAN_EVT_W-1:0] = s_r.evt_stat;
            end
            `PAN_IDX_EVT_MASK: begin
                rd_word[`PAN_EVT_W-1:0] = s_r.evt_mask;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        // Write address and data channels, taken in either order.
        if (aw_hs) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_idx  = I_AWADDR[`PAN_AXI_AW-1:`PAN_IDX_LSB];
        end
        if (w_hs) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata  = I_WDATA[`PAN_REG_W-1:0];
            s_nxt.wstrb  = {I_WSTRB[`PAN_LANE1], I_WSTRB[`PAN_LANE0]};
        end
        if (wr_fire) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            case (s_r.aw_idx)
                `PAN_IDX_NP, `PAN_IDX_EXT, `PAN_IDX_ICTL, `PAN_IDX_LB,
                `PAN_IDX_EVT_STAT, `PAN_IDX_EVT_MASK: begin
                    s_nxt.bresp = `PAN_RESP_OKAY;
                end
                default: begin
                    s_nxt.bresp = `PAN_RESP_SLVERR;
                end
            endcase
        end
        if (s_r.bvalid && I_BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        // Read channel answers one cycle after the address is taken.
        if (ar_hs) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_word;
            s_nxt.rresp  = rd_hit ? `PAN_RESP_OKAY : `PAN_RESP_SLVERR;
        end
        if (s_r.rvalid && I_RREADY) begin
            s_nxt.rvalid = 1'b0;
        end

        // Capture of each received page from the link side.
        if (I_PAGE_VALID) begin
            s_nxt.np_page = I_PAGE;
        end

        // Interrupt enable and status of the auto-negotiation interrupt.
        if (wr_ictl) begin
            s_nxt.an_irq_en = s_r.wdata[`PAN_ICTL_EN_BIT];
        end
        if (stat_clr_wr) begin
            s_nxt.an_irq_stat = 1'b0;
        end
        if (I_AN_DONE) begin
            s_nxt.an_irq_stat = 1'b1;
        end
        if (!s_nxt.an_irq_en) begin
            s_nxt.an_irq_stat = 1'b0;
        end

        // Loopback position comes from the strap once after reset.
        if (!s_r.strap_done) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.lb_pos     = I_LOOPBACK_POS_DEFAULT;
        end else if (wr_lane0 && (s_r.aw_idx == `PAN_IDX_LB)) begin
            s_nxt.lb_pos = s_r.wdata[`PAN_LB_POS_BIT];
        end
        s_nxt.mac_lb  = I_LOOPBACK_EN && !s_nxt.lb_pos;
        s_nxt.xcvr_lb = I_LOOPBACK_EN && s_nxt.lb_pos;

        // Sticky event bits; a new event wins over a clear in the same cycle.
        s_nxt.evt_stat = (s_r.evt_stat & ~evt_clr) | evt_set;
        if (wr_lane0 && (s_r.aw_idx == `PAN_IDX_EVT_MASK)) begin
            s_nxt.evt_mask = s_r.wdata[`PAN_EVT_W-1:0];
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            s_r           <= '0;
            s_r.an_irq_en <= `PAN_ICTL_EN_RST;
            s_r.evt_mask  <= `PAN_EVT_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign O_BVALID          = s_r.bvalid;
    assign O_BRESP           = s_r.bresp;
    assign O_RVALID          = s_r.rvalid;
    assign O_RRESP           = s_r.rresp;
    assign O_RDATA           = {{(`PAN_AXI_DW-`PAN_REG_W){1'b0}}, s_r.rdata};
    assign O_MAC_LOOPBACK    = s_r.mac_lb;
    assign O_XCVR_LOOPBACK   = s_r.xcvr_lb;
    assign O_AUTONEG_IRQ_OUT = s_r.an_irq_stat;
    assign O_IRQ             = |(s_r.evt_stat & s_r.evt_mask);

    // Checks run on the bus clock and rest while reset is held, so the
    // asynchronous clear of the state never counts as a violation.
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    AST_NP_MORE: assert property (
        I_PAGE_VALID |=> s_r.np_page.more_pages == $past(I_PAGE.more_pages))
        else $error("next page bit not captured");
    AST_NP_ACK: assert property (
        I_PAGE_VALID ##1 (!I_PAGE_VALID)[*2] |-> s_r.np_page.ack == $past(I_PAGE.ack, 2))
        else $error("acknowledge bit not held");
    AST_NP_CODE: assert property (
        I_PAGE_VALID |=> s_r.np_page.code == $past(I_PAGE.code)
                         && s_r.np_page.msg_page == $past(I_PAGE.msg_page))
        else $error("code field or message flag wrong");
    AST_NP_ACK2: assert property (
        !I_PAGE_VALID |=> $stable(s_r.np_page.ack2))
        else $error("comply bit changed without a page");
    AST_NP_TOGGLE: assert property (
        I_PAGE_VALID |=> s_r.np_page.toggle == $past(I_PAGE.toggle))
        else $error("toggle bit not captured");
    AST_EXT_FD: assert property (
        (ar_hs && ar_idx == `PAN_IDX_EXT) |=> O_RVALID && O_RDATA[15])
        else $error("extended status full duplex not one");
    AST_EXT_NONE: assert property (
        (ar_hs && ar_idx == `PAN_IDX_EXT) |=> O_RDATA[14:12] == 3'h0)
        else $error("extended status denied abilities not zero");
    AST_IRQ_SET: assert property (
        (I_AN_DONE && s_r.an_irq_en && !en_off_wr) |=> O_AUTONEG_IRQ_OUT)
        else $error("completion did not set interrupt status");
    AST_IRQ_HOLD: assert property (
        (s_r.an_irq_stat && !stat_clr_wr && !en_off_wr) |=> s_r.an_irq_stat)
        else $error("interrupt status dropped without a clear");
    AST_IRQ_FORCE: assert property (
        !s_r.an_irq_en |-> !s_r.an_irq_stat)
        else $error("status set while interrupt disabled");
    AST_IRQ_PORT: assert property (
        (ar_hs && ar_idx == `PAN_IDX_ICTL) |=>
            O_RDATA[`PAN_ICTL_STAT_BIT] == $past(O_AUTONEG_IRQ_OUT))
        else $error("interrupt port differs from status");
    AST_EN_WRITE: assert property (
        wr_ictl |=> s_r.an_irq_en == $past(s_r.wdata[`PAN_ICTL_EN_BIT]))
        else $error("enable bit write lost");
    AST_LB_MAC: assert property (
        s_r.strap_done |=> O_MAC_LOOPBACK == ($past(I_LOOPBACK_EN) && !s_r.lb_pos))
        else $error("MAC loopback wrong");
    AST_LB_XCVR: assert property (
        s_r.strap_done |=> O_XCVR_LOOPBACK == ($past(I_LOOPBACK_EN) && s_r.lb_pos))
        else $error("transceiver loopback wrong");
    AST_LB_OFF: assert property (
        !I_LOOPBACK_EN |=> !O_MAC_LOOPBACK && !O_XCVR_LOOPBACK)
        else $error("loopback active while disabled");
    AST_RSVD_LB: assert property (
        (ar_hs && ar_idx == `PAN_IDX_LB) |=> O_RDATA[`PAN_AXI_DW-1:1] == '0)
        else $error("reserved loopback bits not zero");

    // Bus channels: answers stand until taken and hold off new requests.
    AST_B_STAND: assert property (
        (O_BVALID && !I_BREADY) |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped before it was taken");
    AST_R_STAND: assert property (
        (O_RVALID && !I_RREADY) |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
        else $error("read answer changed before it was taken");
    AST_W_BLOCK: assert property (
        O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write channels open while a response is pending");
    AST_AR_BLOCK: assert property (
        O_RVALID |-> !O_ARREADY)
        else $error("read address open while read data is pending");
    AST_RD_ERR: assert property (
        (ar_hs && !rd_hit) |=> O_RRESP == `PAN_RESP_SLVERR && O_RDATA == '0)
        else $error("unmapped read not refused");

    // Reserved bits, read-only registers and the strap.
    AST_RDATA_HI: assert property (
        O_RVALID |-> O_RDATA[`PAN_AXI_DW-1:`PAN_REG_W] == '0)
        else $error("upper read data bits not zero");
    AST_RSVD_ICTL: assert property (
        (ar_hs && ar_idx == `PAN_IDX_ICTL) |=>
            O_RDATA[`PAN_AXI_DW-1:`PAN_ICTL_STAT_BIT+1] == '0)
        else $error("reserved interrupt control bits not zero");
    AST_NP_RO: assert property (
        (wr_fire && s_r.aw_idx == `PAN_IDX_NP && !I_PAGE_VALID) |=> $stable(s_r.np_page))
        else $error("write changed the received page");
    AST_STRAP: assert property (
        $rose(s_r.strap_done) |-> s_r.lb_pos == $past(I_LOOPBACK_POS_DEFAULT))
        else $error("loopback position not taken from strap");

    // Interrupt and event flags: a new event wins over a clear; loopback outputs never both set.
    AST_IRQ_SET_WINS: assert property (
        (I_AN_DONE && stat_clr_wr && !en_off_wr) |=> O_AUTONEG_IRQ_OUT)
        else $error("status clear beat a completion in the same cycle");
    AST_EVT_AN: assert property (
        I_AN_DONE |=> s_r.evt_stat[`PAN_EVT_AN_BIT])
        else $error("completion event not recorded");
    AST_EVT_PAGE: assert property (
        I_PAGE_VALID |=> s_r.evt_stat[`PAN_EVT_PAGE_BIT])
        else $error("page event not recorded");
    AST_EVT_CLR: assert property (
        (evt_clr[`PAN_EVT_AN_BIT] && !I_AN_DONE) |=> !s_r.evt_stat[`PAN_EVT_AN_BIT])
        else $error("completion event not cleared by a write of one");
    AST_EVT_HOLD: assert property (
        (s_r.evt_stat[`PAN_EVT_AN_BIT] && !evt_clr[`PAN_EVT_AN_BIT]) |=>
            s_r.evt_stat[`PAN_EVT_AN_BIT])
        else $error("completion event dropped without a clear");
    AST_LB_EXCL: assert property (
        !(O_MAC_LOOPBACK && O_XCVR_LOOPBACK))
        else $error("loopback applied in two places at once");

    COV_IRQ_SET: cover property (I_AN_DONE && s_r.an_irq_en ##1 O_AUTONEG_IRQ_OUT);
    COV_IRQ_CLR: cover property (s_r.an_irq_stat && stat_clr_wr ##1 !s_r.an_irq_stat);
    COV_PAGE: cover property (I_PAGE_VALID ##1 (ar_hs && ar_idx == `PAN_IDX_NP));
    COV_XCVR_LB: cover property (O_XCVR_LOOPBACK);
    COV_MAC_LB: cover property (O_MAC_LOOPBACK);

endmodule : pan_regs

`default_nettype wire

/* File: tb/pan_lp_model.sv */
// Link partner model: delivers received pages and completion pulses.
// Assumes it runs on the register bank's clock and is driven by bench tasks.
`default_nettype none
module pan_lp_model (
    // Clock.
    input  wire logic          i_clk,
    // Link-side events and page.
    output logic               o_an_done,
    output logic               o_page_valid,
    output pan_pkg::pan_page_s o_page
);
    timeunit 1ns;
    timeprecision 1ns;
    import pan_pkg::*;

    initial begin
        o_an_done = 1'b0;
        o_page_valid = 1'b0;
        o_page = pan_page_s'(16'hFFFF);
    end

    // Outside its valid cycle the page shows the inverse of the last page.
    task automatic send_page(input pan_page_s p);
        @(posedge i_clk);
        o_page <= p;
        o_page_valid <= 1'b1;
        @(posedge i_clk);
        o_page_valid <= 1'b0;
        o_page <= ~p;
    endtask : send_page

    task automatic finish_an();
        @(posedge i_clk);
        o_an_done <= 1'b1;
        @(posedge i_clk);
        o_an_done <= 1'b0;
    endtask : finish_an
endmodule : pan_lp_model
`default_nettype wire

/* File: tb/pan_regs_tb_top.sv */
// Self-checking bench for the auto-negotiation register bank.
// Assumes the package, the design and the partner model are compiled first.
`default_nettype none
module pan_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pan_pkg::*;

    logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready, lb_en, lb_strap;
    logic        awready, wready, bvalid, arready, rvalid, mac_lb, xcvr_lb;
    logic        an_irq, irq, an_done, pg_valid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    pan_page_s   page;
    int          fail_count = 0;
    int          total_checks = 0;

    pan_regs pan_regs_inst (.I_MCLK(mclk), .I_RST(rst), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready),
        .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
        .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
        .I_AN_DONE(an_done), .I_PAGE_VALID(pg_valid), .I_PAGE(page),
        .I_LOOPBACK_EN(lb_en), .I_LOOPBACK_POS_DEFAULT(lb_strap), .O_MAC_LOOPBACK(mac_lb),
        .O_XCVR_LOOPBACK(xcvr_lb), .O_AUTONEG_IRQ_OUT(an_irq), .O_IRQ(irq));
    pan_lp_model pan_lp_model_inst (.i_clk(mclk), .o_an_done(an_done),
        .o_page_valid(pg_valid), .o_page(page));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hF;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        r = bresp;
        bready <= 1'b0;
        if (n >= 40) begin
            fail_count++;
            $display("[FAIL] bvalid expected 1 seen 0");
            end_of_test();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 40) begin
            fail_count++;
            $display("[FAIL] rvalid expected 1 seen 0");
            end_of_test();
        end
    endtask : rd

    task automatic t_reset();
        rd(8'h40);
        chk("ictl reset", 32'h00000001, d);
        rd(8'h3C);
        chk("ext status", 32'h00008000, d);
        rd(8'h20);
        chk("np reset", 32'h00000000, d);
        rd(8'h44);
        chk("lb strap", 32'h00000001, d);
        chk("xcvr lb off", 32'h0, xcvr_lb);
        $display("test reset done");
    endtask : t_reset

    task automatic t_page();
        pan_lp_model_inst.send_page(pan_page_s'(16'hEDA5));
        rd(8'h20);
        chk("np page1", 32'h0000EDA5, d);
        pan_lp_model_inst.send_page(pan_page_s'(16'h125A));
        rd(8'h20);
        chk("np page2", 32'h0000125A, d);
        $display("test page done");
    endtask : t_page

    task automatic t_irq();
        pan_lp_model_inst.finish_an();
        @(posedge mclk);
        chk("an irq set", 32'h1, an_irq);
        wr(8'h40, 32'h00000003);
        rd(8'h40);
        chk("ictl hold", 32'h00000003, d);
        wr(8'h40, 32'h00000001);
        chk("an irq clear", 32'h0, an_irq);
        wr(8'h40, 32'h00000000);
        pan_lp_model_inst.finish_an();
        @(posedge mclk);
        rd(8'h40);
        chk("ictl disabled", 32'h00000000, d);
        chk("an irq disabled", 32'h0, an_irq);
        wr(8'h40, 32'h00000001);
        rd(8'h40);
        chk("ictl enable rw", 32'h00000001, d);
        $display("test irq done");
    endtask : t_irq

    task automatic t_evt();
        rd(8'h60);
        chk("evt stat", 32'h00000003, d);
        chk("irq masked", 32'h0, irq);
        wr(8'h64, 32'h00000001);
        chk("irq unmasked", 32'h1, irq);
        wr(8'h60, 32'h00000001);
        chk("irq cleared", 32'h0, irq);
        rd(8'h60);
        chk("evt stat w1c", 32'h00000002, d);
        wr(8'h64, 32'h00000003);
        chk("irq page", 32'h1, irq);
        wr(8'h60, 32'h00000002);
        chk("irq page clr", 32'h0, irq);
        $display("test evt done");
    endtask : t_evt

    task automatic t_lb();
        @(posedge mclk);
        lb_en <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("xcvr lb", 32'h1, xcvr_lb);
        chk("mac lb off", 32'h0, mac_lb);
        wr(8'h44, 32'h00000000);
        repeat (2) @(posedge mclk);
        chk("mac lb", 32'h1, mac_lb);
        chk("xcvr lb off", 32'h0, xcvr_lb);
        lb_en <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("no lb", 32'h0, {30'h0, mac_lb, xcvr_lb});
        $display("test loopback done");
    endtask : t_lb

    task automatic t_bad();
        rd(8'h80);
        chk("unmapped rresp", 32'h2, r);
        chk("unmapped rdata", 32'h0, d);
        wr(8'h80, 32'h0000FFFF);
        chk("unmapped bresp", 32'h2, r);
        wr(8'h3C, 32'h00000000);
        chk("ro bresp", 32'h0, r);
        rd(8'h3C);
        chk("ext after wr", 32'h00008000, d);
        wr(8'h20, 32'h0000FFFF);
        rd(8'h20);
        chk("np after wr", 32'h0000125A, d);
        wr(8'h44, 32'hFFFFFFFF);
        rd(8'h44);
        chk("lb reserved", 32'h00000001, d);
        $display("test bad access done");
    endtask : t_bad

    // Reset in mid-run with the strap low: defaults return, position follows strap.
    task automatic t_rerst();
        wr(8'h44, 32'h00000001);
        wr(8'h40, 32'h00000000);
        wr(8'h64, 32'h00000003);
        @(posedge mclk);
        lb_strap <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h40);
        chk("ictl rerst", 32'h00000001, d);
        rd(8'h44);
        chk("lb strap low", 32'h00000000, d);
        rd(8'h20);
        chk("np rerst", 32'h00000000, d);
        rd(8'h64);
        chk("mask rerst", 32'h00000000, d);
        rd(8'h60);
        chk("evt rerst", 32'h00000000, d);
        chk("irq rerst", 32'h0, irq);
        chk("an irq rerst", 32'h0, an_irq);
        $display("test mid-run reset done");
    endtask : t_rerst

    initial begin
        rst = 1'b1;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        lb_en = 1'b0;
        lb_strap = 1'b1;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_page();
        t_irq();
        t_evt();
        t_lb();
        t_bad();
        t_rerst();
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule : pan_regs_tb_top
`default_nettype wire
